/* File: pkg/occ_params.svh */
// Register indices, field reset values and selector codes of the compare channel
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH

`define OCC_ADDR_W        4
`define OCC_IDX_CTL_ONE   4'h0
`define OCC_IDX_CTL_TWO   4'h1
`define OCC_IDX_PRI_LO    4'h2
`define OCC_IDX_SEC_LO    4'h3
`define OCC_IDX_PRI_HI    4'h4
`define OCC_IDX_SEC_HI    4'h5
`define OCC_IDX_TMR_LO    4'h6
`define OCC_IDX_TMR_HI    4'h7

`define OCC_CTL_ONE_RESET 16'h0000
`define OCC_CTL_TWO_RESET 16'h000C
`define OCC_SEL_NONE      5'h00
`define OCC_SEL_SEC_MATCH 5'h1F
`define OCC_MASK_16       32'h0000FFFF
`define OCC_MASK_32       32'hFFFFFFFF
`define OCC_TMR_ZERO      32'h00000000
`define OCC_TMR_STEP      32'h00000001

`endif

/* File: pkg/occ_pkg.sv */
// Types shared by the output compare channel
`include "occ_params.svh"
`default_nettype none
package occ_pkg;

    typedef enum logic [2:0] {
        MODE_OFF       = 3'b000,
        MODE_SHOT_HIGH = 3'b001,
        MODE_SHOT_LOW  = 3'b010,
        MODE_TOGGLE    = 3'b011,
        MODE_DBL_SHOT  = 3'b100,
        MODE_DBL_CONT  = 3'b101,
        MODE_PWM_EDGE  = 3'b110,
        MODE_PWM_CTR   = 3'b111
    } mode_t;

    typedef struct packed {
        logic [7:0] rsv_hi;
        logic       fault_input_enable_bit;
        logic [1:0] rsv_mid;
        logic       fault_status_flag;
        logic       rsv_lo;
        mode_t      compare_mode_field;
    } ctl_one_t;

    typedef struct packed {
        logic       fault_mode_bit;
        logic       fault_output_level_bit;
        logic       fault_tristate_bit;
        logic       output_invert_bit;
        logic [2:0] rsv;
        logic       cascade_enable_bit;
        logic       trigger_select_bit;
        logic       trigger_status_bit;
        logic       pin_direction_bit;
        logic [4:0] source_select_field;
    } ctl_two_t;

    typedef struct packed {
        logic [`OCC_ADDR_W-1:0] addr;
        logic [15:0]            wdata;
        logic                   wr;
        logic                   rd;
    } bus_req_t;

    typedef struct packed {
        ctl_one_t    c1;
        ctl_two_t    c2;
        logic [31:0] pri;
        logic [31:0] sec;
        logic [31:0] pri_buf;
        logic [31:0] sec_buf;
        logic [31:0] timer;
        logic        level;
        logic        done;
        logic        phase;
        logic        fault;
        logic [15:0] rdata;
        logic        pin_out;
        logic        pin_oe;
        logic        trig_out;
    } state_t;

endpackage
`default_nettype wire

/* File: core/output_compare_channel.sv */
// Output compare channel: timer, compare modes, fault, trigger and registers
// Operation
// - Mode 111: high on primary, low on secondary
// - Mode 110: high at zero, low on primary
// - Mode 101: start low, alternate toggles continuously
// - Mode 100: start low, one pulse only
// - Mode 011: toggle on every primary match
// - Mode 010: start high, low once on primary
// - Mode 001: start low, high once on primary
// - Mode 000: channel disabled, no activity
// - Compare values buffered only in pulse modes
// - Fault mode 1: also needs software flag clear
// - Fault mode 0: ends on removal plus period
// - Fault drives output to fault level bit
// - Fault tristate bit floats pin on fault
// - Invert bit inverts channel output
// - Cascade bit makes one 32-bit compare
// - Trigger select: trigger start versus synchronize
// - Trigger: timer held clear, status set running
// - Turning channel off emits trigger out
// - Source select resets to 01100; 11111 secondary
// - External fault acted on only when enabled
//
// The register offsets and strobed register access were left to the implementer.
`include "occ_params.svh"
`default_nettype none

module output_compare_channel
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // Register port
    input  wire logic [`OCC_ADDR_W-1:0] addr,
    input  wire logic [15:0]            wdata,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    output logic      [15:0]            rdata,
    // Event sources, indexed by the source select code
    input  wire logic [31:0]            sync_events,
    input  wire logic                   external_fault_input,
    // Compare output pin and trigger out
    output logic                        pin_out,
    output logic                        pin_oe,
    output logic                        trig_out
);

    occ_pkg::state_t s;
    occ_pkg::state_t n;
    occ_pkg::bus_req_t req;

    logic [31:0] mask;
    logic        pri_m;
    logic        sec_m;
    logic        pwm;
    logic        sel_evt;
    logic        fault_act;
    logic        period_start;

    assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

    assign mask = s.c2.cascade_enable_bit ? `OCC_MASK_32 : `OCC_MASK_16;
    assign pri_m = (s.timer == (s.pri & mask));
    assign sec_m = (s.timer == (s.sec & mask));
    assign pwm = (s.c1.compare_mode_field == occ_pkg::MODE_PWM_EDGE)
              || (s.c1.compare_mode_field == occ_pkg::MODE_PWM_CTR);
    assign period_start = (s.timer == `OCC_TMR_ZERO);
    assign fault_act = s.c1.fault_input_enable_bit
                    && external_fault_input;

    // Source 11111 reuses the secondary match, 00000 selects none, others come from outside
    always_comb
    begin
        unique case (s.c2.source_select_field)
            `OCC_SEL_NONE:      sel_evt = 1'b0;
            `OCC_SEL_SEC_MATCH: sel_evt = sec_m;
            default:            sel_evt = sync_events[s.c2.source_select_field];
        endcase
    end

    always_comb
    begin
        n = s;
        n.trig_out = 1'b0;

        // Channel timer
        if (s.c1.compare_mode_field == occ_pkg::MODE_OFF)
            n.timer = `OCC_TMR_ZERO;
        else if (s.c2.trigger_select_bit && !s.c2.trigger_status_bit)
            n.timer = `OCC_TMR_ZERO;
        else if (!s.c2.trigger_select_bit && sel_evt)
            n.timer = `OCC_TMR_ZERO;
        else
            n.timer = (s.timer + `OCC_TMR_STEP) & mask;

        // In the PWM modes shadow values move to the active pair at each period start
        if (pwm && period_start)
        begin
            n.pri = s.pri_buf;
            n.sec = s.sec_buf;
        end

        // Compare behaviour per mode
        unique case (s.c1.compare_mode_field)
            occ_pkg::MODE_OFF:
                n.level = 1'b0;
            occ_pkg::MODE_SHOT_HIGH:
                if (!s.done && pri_m)
                begin
                    n.level = 1'b1;
                    n.done = 1'b1;
                end
            occ_pkg::MODE_SHOT_LOW:
                if (!s.done && pri_m)
                begin
                    n.level = 1'b0;
                    n.done = 1'b1;
                end
            occ_pkg::MODE_TOGGLE:
                if (pri_m)
                    n.level = !s.level;
            occ_pkg::MODE_DBL_SHOT:
                if (!s.done && !s.phase && pri_m)
                begin
                    n.level = 1'b1;
                    n.phase = 1'b1;
                end
                else if (!s.done && s.phase && sec_m)
                begin
                    n.level = 1'b0;
                    n.done = 1'b1;
                end
            occ_pkg::MODE_DBL_CONT:
                if ((!s.phase && pri_m) || (s.phase && sec_m))
                begin
                    n.level = !s.level;
                    n.phase = !s.phase;
                end
            occ_pkg::MODE_PWM_EDGE:
                // A primary value of zero gives zero duty, so low wins
                if (pri_m)
                    n.level = 1'b0;
                else if (period_start)
                    n.level = 1'b1;
            occ_pkg::MODE_PWM_CTR:
                if (sec_m)
                    n.level = 1'b0;
                else if (pri_m)
                    n.level = 1'b1;
        endcase

        // Register writes
        if (req.wr)
        begin
            unique case (req.addr)
                `OCC_IDX_CTL_ONE:
                begin
                    n.c1.fault_input_enable_bit = req.wdata[7];
                    // The flag is cleared by writing zero, never set by software
                    if (!req.wdata[4])
                        n.c1.fault_status_flag = 1'b0;
                    n.c1.compare_mode_field = occ_pkg::mode_t'(req.wdata[2:0]);
                    if (req.wdata[2:0] != s.c1.compare_mode_field)
                    begin
                        n.timer = `OCC_TMR_ZERO;
                        n.level = (req.wdata[2:0] == occ_pkg::MODE_SHOT_LOW);
                        n.done = 1'b0;
                        n.phase = 1'b0;
                        n.fault = 1'b0;
                    end
                    if (s.c1.compare_mode_field != occ_pkg::MODE_OFF
                        && req.wdata[2:0] == occ_pkg::MODE_OFF)
                        n.trig_out = 1'b1;
                end
                `OCC_IDX_CTL_TWO:
                begin
                    n.c2 = occ_pkg::ctl_two_t'(req.wdata);
                    n.c2.rsv = 3'h0;
                end
                `OCC_IDX_PRI_LO:
                begin
                    n.pri_buf[15:0] = req.wdata;
                    if (!pwm)
                        n.pri[15:0] = req.wdata;
                end
                `OCC_IDX_SEC_LO:
                begin
                    n.sec_buf[15:0] = req.wdata;
                    if (!pwm)
                        n.sec[15:0] = req.wdata;
                end
                `OCC_IDX_PRI_HI:
                begin
                    n.pri_buf[31:16] = req.wdata;
                    if (!pwm)
                        n.pri[31:16] = req.wdata;
                end
                `OCC_IDX_SEC_HI:
                begin
                    n.sec_buf[31:16] = req.wdata;
                    if (!pwm)
                        n.sec[31:16] = req.wdata;
                end
                default: ;
            endcase
        end

        // Hardware sets come last so they win over a same-cycle clear
        if (s.c2.trigger_select_bit && sel_evt
            && s.c1.compare_mode_field != occ_pkg::MODE_OFF)
            n.c2.trigger_status_bit = 1'b1;
        if (fault_act)
            n.c1.fault_status_flag = 1'b1;

        // Fault entry and exit, only meaningful in the pulse modes
        if (pwm && fault_act)
            n.fault = 1'b1;
        else if (s.fault && !fault_act && period_start
                 && (!s.c2.fault_mode_bit || !n.c1.fault_status_flag))
            n.fault = 1'b0;

        // Pin stage from the next-state values, so it stays registered
        n.pin_out = n.fault ? n.c2.fault_output_level_bit
                            : (n.level ^ n.c2.output_invert_bit);
        n.pin_oe = !n.c2.pin_direction_bit
                && !(n.fault && n.c2.fault_tristate_bit);

        // Read data stands only in the cycle after the read strobe
        n.rdata = 16'h0000;
        if (req.rd)
        begin
            unique case (req.addr)
                `OCC_IDX_CTL_ONE: n.rdata = s.c1;
                `OCC_IDX_CTL_TWO: n.rdata = s.c2;
                `OCC_IDX_PRI_LO:  n.rdata = s.pri_buf[15:0];
                `OCC_IDX_SEC_LO:  n.rdata = s.sec_buf[15:0];
                `OCC_IDX_PRI_HI:  n.rdata = s.pri_buf[31:16];
                `OCC_IDX_SEC_HI:  n.rdata = s.sec_buf[31:16];
                `OCC_IDX_TMR_LO:  n.rdata = s.timer[15:0];
                `OCC_IDX_TMR_HI:  n.rdata = s.timer[31:16];
                default:          n.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s <= '0;
            s.c1 <= `OCC_CTL_ONE_RESET;
            s.c2 <= `OCC_CTL_TWO_RESET;
            s.pin_oe <= 1'b1;
        end
        else
            s <= n;
    end

    assign rdata = s.rdata;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign trig_out = s.trig_out;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence seq_turn_off;
        wr_en && addr == `OCC_IDX_CTL_ONE && wdata[2:0] == 3'b000
        && s.c1.compare_mode_field != occ_pkg::MODE_OFF;
    endsequence

    sequence seq_one_pulse;
        trig_out ##1 !trig_out;
    endsequence

    sequence seq_quiet;
        !wr_en && !fault_act && !s.fault;
    endsequence

    chk_off_trigger: assert property (seq_turn_off |=> seq_one_pulse)
        else $error("turning off did not give one trigger pulse");

    chk_off_quiet: assert property (
        (s.c1.compare_mode_field == occ_pkg::MODE_OFF && !wr_en) ##1 !wr_en
        |-> !s.level ##1 !s.level)
        else $error("disabled channel changed its level");

    chk_edge_start: assert property (
        (seq_quiet and (s.c1.compare_mode_field == occ_pkg::MODE_PWM_EDGE
        && period_start && !pri_m))
        |=> pin_out == !s.c2.output_invert_bit)
        else $error("edge pulse did not rise at zero");

    chk_center_set: assert property (
        (seq_quiet and (s.c1.compare_mode_field == occ_pkg::MODE_PWM_CTR
        && pri_m && !sec_m)) |=> s.level)
        else $error("center pulse did not rise on primary match");

    chk_toggle_flip: assert property (
        s.c1.compare_mode_field == occ_pkg::MODE_TOGGLE && !wr_en && pri_m
        |=> s.level != $past(s.level))
        else $error("toggle mode missed a primary match");

    chk_fault_pin: assert property (
        pwm && fault_act && !wr_en
        |=> s.fault && pin_out == s.c2.fault_output_level_bit)
        else $error("fault did not force the fault level");

    chk_fault_float: assert property (
        s.fault && s.c2.fault_tristate_bit |-> !pin_oe)
        else $error("pin driven during tristate fault");

    chk_flag_holds: assert property (
        s.fault && s.c2.fault_mode_bit && s.c1.fault_status_flag && !wr_en
        |=> s.fault)
        else $error("fault left while status flag still set");

    chk_trig_hold: assert property (
        s.c2.trigger_select_bit && !s.c2.trigger_status_bit && !sel_evt
        && !wr_en |=> s.timer == `OCC_TMR_ZERO)
        else $error("timer ran before trigger");

    chk_dir_float: assert property (
        s.c2.pin_direction_bit && !wr_en |=> !pin_oe)
        else $error("pin driven with direction bit set");

    chk_shot_high: assert property (
        s.c1.compare_mode_field == occ_pkg::MODE_SHOT_HIGH && !wr_en
        && !s.done && pri_m |=> s.level && s.done)
        else $error("single shot did not go high on match");

    chk_shot_low: assert property (
        s.c1.compare_mode_field == occ_pkg::MODE_SHOT_LOW && !wr_en
        && !s.done && pri_m |=> !s.level && s.done)
        else $error("single shot did not go low on match");

    chk_dbl_first: assert property (
        s.c1.compare_mode_field == occ_pkg::MODE_DBL_SHOT && !wr_en
        && !s.done && !s.phase && pri_m |=> s.level && s.phase)
        else $error("double shot did not rise on primary match");

    chk_dbl_single: assert property (
        s.c1.compare_mode_field == occ_pkg::MODE_DBL_SHOT && !wr_en
        && s.done |=> !s.level && s.done)
        else $error("double shot pulsed a second time");

    chk_cont_alternate: assert property (
        s.c1.compare_mode_field == occ_pkg::MODE_DBL_CONT && !wr_en
        && s.phase && sec_m |=> !s.phase && s.level != $past(s.level))
        else $error("continuous pulse missed a secondary match");

    chk_center_clear: assert property (
        s.c1.compare_mode_field == occ_pkg::MODE_PWM_CTR && !wr_en
        && sec_m |=> !s.level)
        else $error("center pulse did not fall on secondary match");

    chk_edge_clear: assert property (
        s.c1.compare_mode_field == occ_pkg::MODE_PWM_EDGE && !wr_en
        && pri_m |=> !s.level)
        else $error("edge pulse did not fall on primary match");

    chk_shadow_load: assert property (
        pwm && period_start && !wr_en
        |=> s.pri == $past(s.pri_buf) && s.sec == $past(s.sec_buf))
        else $error("shadow compare values not loaded at period start");

    chk_sync_clear: assert property (
        !s.c2.trigger_select_bit && sel_evt && !wr_en
        |=> s.timer == `OCC_TMR_ZERO)
        else $error("sync event did not clear the timer");

    chk_output_invert: assert property (
        !s.fault |-> pin_out == (s.level ^ s.c2.output_invert_bit))
        else $error("pin does not follow level and invert bit");

    chk_fault_release: assert property (
        s.fault && !s.c2.fault_mode_bit && !fault_act && period_start
        && !wr_en |=> !s.fault)
        else $error("fault held past period start with source gone");

    chk_mode_init: assert property (
        wr_en && addr == `OCC_IDX_CTL_ONE
        && wdata[2:0] != s.c1.compare_mode_field
        |=> s.timer == `OCC_TMR_ZERO
        && s.level == (s.c1.compare_mode_field == occ_pkg::MODE_SHOT_LOW))
        else $error("mode change did not restart from initial level");

endmodule // output_compare_channel
`default_nettype wire

/* File: sim/pin_load.sv */
// Load model on the compare output pin
`default_nettype none

module pin_load
(
    // Clock
    input  wire logic ref_clk,
    // Driver side
    input  wire logic drv,
    input  wire logic drv_en,
    // Pad level seen by the load
    output logic      pad
);
    timeunit 1ns;
    timeprecision 1ns;

    logic last_r = 1'b0;

    always_ff @(posedge ref_clk)
    begin
        if (drv_en)
            last_r <= drv;
    end

    // A floating pad must not keep the old level, so show its inverse
    assign pad = drv_en ? drv : ~last_r;

endmodule // pin_load
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench of the output compare channel
`include "occ_params.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [2:0]  mode;
        logic [15:0] pri;
        logic [15:0] sec;
        logic [15:0] ctl2;
        logic [7:0]  k;
        logic        pin;
        logic        oe;
    } row_t;

    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [31:0] sync_events = 32'h00000000;
    logic        external_fault_input = 1'b0;
    logic [15:0] rdata;
    logic        pin_out;
    logic        pin_oe;
    logic        trig_out;
    logic        pad;
    int          errors = 0;
    int          total_checks = 0;

    // Mode, primary, secondary, control two, cycles after mode write, pin, oe
    localparam row_t ROWS [17] = '{
        '{3'h0, 16'h0003, 16'h0000, 16'h000C, 8'h05, 1'b0, 1'b1},
        '{3'h1, 16'h0003, 16'h0000, 16'h000C, 8'h03, 1'b0, 1'b1},
        '{3'h1, 16'h0003, 16'h0000, 16'h000C, 8'h05, 1'b1, 1'b1},
        '{3'h2, 16'h0003, 16'h0000, 16'h000C, 8'h03, 1'b1, 1'b1},
        '{3'h2, 16'h0003, 16'h0000, 16'h000C, 8'h05, 1'b0, 1'b1},
        '{3'h3, 16'h0002, 16'h0000, 16'h000C, 8'h02, 1'b0, 1'b1},
        '{3'h3, 16'h0002, 16'h0000, 16'h000C, 8'h04, 1'b1, 1'b1},
        '{3'h4, 16'h0002, 16'h0005, 16'h000C, 8'h04, 1'b1, 1'b1},
        '{3'h4, 16'h0002, 16'h0005, 16'h000C, 8'h0C, 1'b0, 1'b1},
        '{3'h5, 16'h0002, 16'h0005, 16'h000C, 8'h04, 1'b1, 1'b1},
        '{3'h5, 16'h0002, 16'h0005, 16'h000C, 8'h07, 1'b0, 1'b1},
        '{3'h6, 16'h0003, 16'h0007, 16'h001F, 8'h03, 1'b1, 1'b1},
        '{3'h6, 16'h0003, 16'h0007, 16'h001F, 8'h05, 1'b0, 1'b1},
        '{3'h7, 16'h0002, 16'h0005, 16'h001F, 8'h04, 1'b1, 1'b1},
        '{3'h7, 16'h0002, 16'h0005, 16'h001F, 8'h07, 1'b0, 1'b1},
        '{3'h1, 16'h0003, 16'h0000, 16'h100C, 8'h05, 1'b0, 1'b1},
        '{3'h1, 16'h0003, 16'h0000, 16'h002C, 8'h05, 1'b1, 1'b0}
    };

    always #25 ref_clk = ~ref_clk;

    output_compare_channel dut_u (
        .ref_clk              (ref_clk),
        .reset                (reset),
        .addr                 (addr),
        .wdata                (wdata),
        .wr_en                (wr_en),
        .rd_en                (rd_en),
        .rdata                (rdata),
        .sync_events          (sync_events),
        .external_fault_input (external_fault_input),
        .pin_out              (pin_out),
        .pin_oe               (pin_oe),
        .trig_out             (trig_out)
    );

    pin_load load_u (
        .ref_clk (ref_clk),
        .drv     (pin_out),
        .drv_en  (pin_oe),
        .pad     (pad)
    );

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe stays up so writes can follow each other with no gap
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        rd_en <= 1'b0;
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
    endtask

    task automatic settle(input logic [7:0] n);
        wr_en <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        chk(rdata, exp);
        @(negedge ref_clk);
        chk(rdata, 16'h0000);
        @(posedge ref_clk);
    endtask

    // Bounded wait for the pad or the enable to reach a level
    task automatic wait_lvl(input logic use_oe, input logic v);
        int n = 0;
        settle(8'h00);
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (((use_oe ? pin_oe : pad) !== v) && n < 40);
        chk({15'h0000, (use_oe ? pin_oe : pad)}, {15'h0000, v});
        if ((use_oe ? pin_oe : pad) !== v)
            final_report();
        @(posedge ref_clk);
    endtask

    task automatic pulse_src();
        sync_events <= 32'h00001000;
        @(posedge ref_clk);
        sync_events <= 32'h00000000;
    endtask

    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        chk({13'h0000, pin_out, pin_oe, trig_out}, 16'h0002);
        @(posedge ref_clk);
        rd(`OCC_IDX_CTL_ONE, 16'h0000);
        rd(`OCC_IDX_CTL_TWO, 16'h000C);
        wr(`OCC_IDX_CTL_ONE, 16'hFFFF);
        rd(`OCC_IDX_CTL_ONE, 16'h0087);
        wr(`OCC_IDX_CTL_TWO, 16'hFFFF);
        rd(`OCC_IDX_CTL_TWO, 16'hF1FF);
        wr(`OCC_IDX_CTL_TWO, 16'h000C);
        wr(`OCC_IDX_CTL_ONE, 16'h0000);
        wr(4'h9, 16'hFFFF);
        rd(4'h9, 16'h0000);
        wr(`OCC_IDX_PRI_LO, 16'h0005);
        rd(`OCC_IDX_PRI_LO, 16'h0005);
        // The PWM rows select source 11111, the secondary match of this channel
        foreach (ROWS[i])
        begin
            wr(`OCC_IDX_PRI_LO, ROWS[i].pri);
            wr(`OCC_IDX_SEC_LO, ROWS[i].sec);
            wr(`OCC_IDX_CTL_TWO, ROWS[i].ctl2);
            wr(`OCC_IDX_CTL_ONE, {13'h0000, ROWS[i].mode});
            settle(ROWS[i].k);
            @(negedge ref_clk);
            chk({15'h0000, pin_out}, {15'h0000, ROWS[i].pin});
            chk({15'h0000, pin_oe}, {15'h0000, ROWS[i].oe});
            @(posedge ref_clk);
            wr(`OCC_IDX_CTL_ONE, 16'h0000);
            settle(8'h00);
            @(negedge ref_clk);
            chk({15'h0000, trig_out}, {15'h0000, ROWS[i].mode != 3'h0});
            @(negedge ref_clk);
            chk({15'h0000, trig_out}, 16'h0000);
            @(posedge ref_clk);
        end
        wr(`OCC_IDX_PRI_LO, 16'h0002);
        // Upper word must be masked off while cascade is clear
        wr(`OCC_IDX_PRI_HI, 16'h0001);
        wr(`OCC_IDX_CTL_TWO, 16'h000C);
        wr(`OCC_IDX_CTL_ONE, 16'h0003);
        wait_lvl(1'b0, 1'b1);
        pulse_src();
        wait_lvl(1'b0, 1'b0);
        wr(`OCC_IDX_CTL_ONE, 16'h0000);
        wr(`OCC_IDX_CTL_TWO, 16'h008C);
        wr(`OCC_IDX_PRI_LO, 16'h0003);
        wr(`OCC_IDX_CTL_ONE, 16'h0001);
        settle(8'h06);
        rd(`OCC_IDX_TMR_LO, 16'h0000);
        rd(`OCC_IDX_CTL_TWO, 16'h008C);
        pulse_src();
        rd(`OCC_IDX_CTL_TWO, 16'h00CC);
        wait_lvl(1'b0, 1'b1);
        wr(`OCC_IDX_CTL_ONE, 16'h0000);
        wr(`OCC_IDX_CTL_TWO, 16'h601F);
        wr(`OCC_IDX_SEC_LO, 16'h0007);
        wr(`OCC_IDX_CTL_ONE, 16'h0006);
        external_fault_input <= 1'b1;
        settle(8'h04);
        @(negedge ref_clk);
        chk({15'h0000, pin_oe}, 16'h0001);
        @(posedge ref_clk);
        wr(`OCC_IDX_CTL_ONE, 16'h0086);
        settle(8'h03);
        @(negedge ref_clk);
        chk({14'h0000, pin_out, pin_oe}, 16'h0002);
        @(posedge ref_clk);
        rd(`OCC_IDX_CTL_ONE, 16'h0096);
        external_fault_input <= 1'b0;
        wait_lvl(1'b1, 1'b1);
        wr(`OCC_IDX_CTL_TWO, 16'hE01F);
        external_fault_input <= 1'b1;
        settle(8'h03);
        external_fault_input <= 1'b0;
        settle(8'h14);
        @(negedge ref_clk);
        chk({15'h0000, pin_oe}, 16'h0000);
        @(posedge ref_clk);
        wr(`OCC_IDX_CTL_ONE, 16'h0086);
        wait_lvl(1'b1, 1'b1);
        // Reset in mid-run must bring every register back to default
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        chk({13'h0000, pin_out, pin_oe, trig_out}, 16'h0002);
        @(posedge ref_clk);
        rd(`OCC_IDX_CTL_ONE, 16'h0000);
        rd(`OCC_IDX_CTL_TWO, 16'h000C);
        rd(`OCC_IDX_PRI_HI, 16'h0000);
        final_report();
    end

endmodule // tb_top
`default_nettype wire
